// file: fjh_pkg.sv
`default_nettype none
package fjh_pkg;

   // --------------------------------------------------------------
   // jog image layout, offsets in bits from the start device
   // --------------------------------------------------------------
   localparam int AXES = 4;
   localparam int IMG_W = 8;
   localparam int OFS_BASE = 72;
   localparam int OFS_AXIS0 = 72; // axis 0 request / moving
   localparam int OFS_INCH = 76; // inching request
   localparam int OFS_LOW = 77; // low-speed request
   localparam int OFS_HIGH = 78; // high-speed request
   localparam int OFS_DIR = 79; // direction
   localparam int OFS_PERMIT = 76; // jog permit output
   localparam int B_AX = OFS_AXIS0 - OFS_BASE;
   localparam int B_INCH = OFS_INCH - OFS_BASE;
   localparam int B_LOW = OFS_LOW - OFS_BASE;
   localparam int B_HIGH = OFS_HIGH - OFS_BASE;
   localparam int B_DIR = OFS_DIR - OFS_BASE;
   localparam int B_PERMIT = OFS_PERMIT - OFS_BASE;

   // --------------------------------------------------------------
   // timing
   // --------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_US = 1000; // filter tick period
   localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   localparam int FILT_MS = 10;
   localparam int FILT_TICKS = FILT_MS * 1000 / TICK_US;
   localparam int HOLD_MS = 30;
   localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;

   // --------------------------------------------------------------
   // master station registers on apb
   // --------------------------------------------------------------
   localparam logic [11:0] REG_CMD = 12'h000;
   localparam logic [11:0] REG_STAT = 12'h004;
   localparam int CMD_LINK = 8; // link enable bit of command
   localparam logic [8:0] CMD_RST = 9'h000;
   localparam int STAT_PEND = 8; // image not yet sent

   typedef enum logic [1:0] {MODE_NONE, MODE_INCH, MODE_LOW, MODE_HIGH} fjh_mode_t;
   typedef enum logic {DEV_IDLE, DEV_JOG} fjh_state_t;
endpackage
`default_nettype wire

// file: fjh_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// fieldbus jog image between master station and controller
interface fjh_link_if;
   logic [fjh_pkg::IMG_W-1:0] jog_in; // master to device image
   logic [fjh_pkg::IMG_W-1:0] jog_out; // device to master image
   logic link_ok; // fieldbus link alive
   modport dev (input jog_in, input link_ok, output jog_out);
   modport host (output jog_in, output link_ok, input jog_out);
endinterface
`default_nettype wire

// file: fjh_filter.sv
`timescale 1ns/1ps
`default_nettype none
// per-bit debounce: flips only after TICKS stable ticks
module fjh_filter #(
   parameter int W = 8,
   parameter int TICKS = 10
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clr,
   input wire logic tick,
   input wire logic [W-1:0] raw,
   output logic [W-1:0] filt
);
   import fjh_pkg::*;
   localparam int CW = $clog2(TICKS + 1);

   if (TICKS < 1) begin : g_chk
      $error("filter needs at least one tick");
   end

   // --------------------------------------------------------------
   // one counter per input bit
   // --------------------------------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic [CW-1:0] cnt; // ticks seen with raw differing
      // count only while the raw level differs, reset on any bounce
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            cnt <= '0;
            filt[i] <= 1'b0;
         end else if (clr) begin
            cnt <= '0;
            filt[i] <= 1'b0;
         end else if (raw[i] == filt[i]) begin
            cnt <= '0; // short pulse forgotten
         end else if (tick) begin
            if (cnt == CW'(TICKS - 1)) begin
               filt[i] <= raw[i];
               cnt <= '0;
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: fjh_device.sv
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// controller end: jog request handling for up to four axes
module fjh_device #(
   parameter int TICK_CYCLES = fjh_pkg::TICK_CYC,
   parameter int FILT_TICKS_P = fjh_pkg::FILT_TICKS,
   parameter int SPD_W = 16
) (
   input wire logic core_clk,
   input wire logic rst_n,
   fjh_link_if.dev bus,
   input wire logic [fjh_pkg::IMG_W-1:0] io_jog_in,
   output logic [fjh_pkg::IMG_W-1:0] io_jog_out,
   input wire logic pendant_on,
   input wire logic tool_busy,
   input wire logic prog_running,
   input wire logic homing_active,
   input wire logic error_active,
   output logic running_out,
   input wire logic [fjh_pkg::AXES-1:0] axis_present,
   input wire logic [fjh_pkg::AXES-1:0] pos_known,
   input wire logic [fjh_pkg::AXES-1:0] lim_pos_hit,
   input wire logic [fjh_pkg::AXES-1:0] lim_neg_hit,
   input wire logic [SPD_W-1:0] low_speed,
   input wire logic [SPD_W-1:0] high_speed,
   input wire logic [SPD_W-1:0] inch_dist,
   output logic move_en,
   output logic [1:0] move_axis,
   output logic move_neg,
   output logic [SPD_W-1:0] move_speed,
   output logic move_inch,
   output logic [SPD_W-1:0] move_dist
);
   import fjh_pkg::*;
   localparam int TW = $clog2(TICK_CYCLES);

   if (TICK_CYCLES < 2 || FILT_TICKS_P < 1 || AXES > 4) begin : g_chk
      $error("unsupported tick, filter or axis count");
   end

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   // mode priority: inching, then low, then high
   function automatic fjh_mode_t pick_mode(input logic [IMG_W-1:0] img);
      fjh_mode_t m;
      m = MODE_NONE;
      if (img[B_INCH]) begin
         m = MODE_INCH;
      end else if (img[B_LOW]) begin
         m = MODE_LOW;
      end else if (img[B_HIGH]) begin
         m = MODE_HIGH;
      end
      return m;
   endfunction

   // lowest set bit of an axis vector
   function automatic logic [1:0] low_axis(input logic [AXES-1:0] v);
      logic [1:0] a;
      a = 2'h0;
      for (int i = AXES - 1; i >= 0; i--) begin
         if (v[i]) begin
            a = 2'(i);
         end
      end
      return a;
   endfunction

   // --------------------------------------------------------------
   // filter tick divider
   // --------------------------------------------------------------
   logic [TW-1:0] tick_cnt; // cycles within a tick
   logic tick; // one-cycle filter tick
   // divides the core clock down to the filter tick
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
         tick_cnt <= '0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
         tick <= 1'b0;
      end
   end

   // --------------------------------------------------------------
   // input path
   // --------------------------------------------------------------
   logic jog_clr; // sync clear of latched jog state
   logic [IMG_W-1:0] raw_img; // combined request image
   logic [IMG_W-1:0] filt_img; // filtered request image
   assign jog_clr = !bus.link_ok;
   // a dead link contributes nothing; the filter is cleared meanwhile
   assign raw_img = (bus.link_ok ? bus.jog_in : '0) | io_jog_in;

   fjh_filter #(
      .W(IMG_W),
      .TICKS(FILT_TICKS_P)
   ) u_filter (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clr(jog_clr),
      .tick(tick),
      .raw(raw_img),
      .filt(filt_img)
   );

   logic [AXES-1:0] req; // filtered axis requests
   logic [AXES-1:0] prev_req; // requests one cycle ago
   logic [AXES-1:0] cand; // fresh requests for present stations
   assign req = filt_img[B_AX +: AXES];
   assign cand = req & ~prev_req & axis_present;

   // edge memory, cleared on link loss
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_req <= '0;
      end else if (jog_clr) begin
         prev_req <= '0;
      end else begin
         prev_req <= req;
      end
   end

   // running flag: program run or homing
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         running_out <= 1'b0;
      end else begin
         running_out <= prog_running | homing_active;
      end
   end

   // --------------------------------------------------------------
   // jog state machine
   // --------------------------------------------------------------
   fjh_state_t state; // idle or jogging
   fjh_state_t next_state;
   logic [1:0] axis_lat; // jogging axis
   fjh_mode_t mode_lat; // latched mode
   logic dir_lat; // latched direction, high is negative
   logic permit; // current jog permit output
   logic permit_cond; // nothing blocks jogging
   logic accept; // request taken this cycle
   fjh_mode_t sel_mode; // mode chosen by priority

   assign permit_cond = !(pendant_on | tool_busy | running_out | error_active);
   assign sel_mode = pick_mode(filt_img);

   // next state: take a fresh request, drop on release or link loss
   always_comb begin
      next_state = state;
      accept = 1'b0;
      unique case (state)
         DEV_IDLE: begin
            // only with permit high, a mode set and at least one fresh axis request
            if (!jog_clr && permit && |cand && sel_mode != MODE_NONE) begin
               accept = 1'b1;
               next_state = DEV_JOG;
            end
         end
         DEV_JOG: begin
            if (jog_clr || !req[axis_lat]) begin
               next_state = DEV_IDLE;
            end
         end
      endcase
   end

   // state register with synchronous clear on link loss
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= DEV_IDLE;
      end else if (jog_clr) begin
         state <= DEV_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // jog conditions latched only at the accept edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         axis_lat <= 2'h0;
         mode_lat <= MODE_NONE;
         dir_lat <= 1'b0;
      end else if (jog_clr) begin
         axis_lat <= 2'h0;
         mode_lat <= MODE_NONE;
         dir_lat <= 1'b0;
      end else if (accept) begin
         axis_lat <= low_axis(cand);
         mode_lat <= sel_mode;
         dir_lat <= filt_img[B_DIR];
      end
      // later mode or direction changes are not looked at
   end

   // --------------------------------------------------------------
   // status image
   // --------------------------------------------------------------
   logic [AXES-1:0] next_moving; // moving bits after this edge
   logic [IMG_W-1:0] next_img; // status image after this edge
   always_comb begin
      next_moving = '0;
      if (next_state == DEV_JOG) begin
         next_moving[accept ? low_axis(cand) : axis_lat] = 1'b1;
      end
      next_img = '0; // unused bits stay low
      next_img[B_AX +: AXES] = next_moving;
      next_img[B_PERMIT] = next_state == DEV_IDLE && permit_cond;
   end

   // permit and moving bits change on the same edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus.jog_out <= '0;
         io_jog_out <= '0;
         permit <= 1'b0;
      end else if (jog_clr) begin
         bus.jog_out <= '0;
         io_jog_out <= '0;
         permit <= 1'b0;
      end else begin
         bus.jog_out <= next_img;
         io_jog_out <= next_img;
         permit <= next_img[B_PERMIT];
      end
   end

   // --------------------------------------------------------------
   // motion command
   // --------------------------------------------------------------
   logic lim_block; // motion would pass a soft limit
   // limits only apply once the position is known
   assign lim_block = pos_known[axis_lat] &&
      (dir_lat ? lim_neg_hit[axis_lat] : lim_pos_hit[axis_lat]);

   // command one cycle after status rises, stopped on release
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         move_en <= 1'b0;
         move_axis <= 2'h0;
         move_neg <= 1'b0;
         move_speed <= '0;
         move_inch <= 1'b0;
         move_dist <= '0;
      end else begin
         move_en <= state == DEV_JOG && next_state == DEV_JOG && !jog_clr && !lim_block;
         move_axis <= axis_lat;
         move_neg <= dir_lat;
         move_speed <= mode_lat == MODE_HIGH ? high_speed : low_speed;
         move_inch <= mode_lat == MODE_INCH;
         move_dist <= inch_dist;
      end
   end
endmodule
`default_nettype wire

// file: fjh_host.sv
`timescale 1ns/1ps
`default_nettype none
// master station end: apb command registers drive the jog image
module fjh_host #(
   parameter int HOLD_CYCLES = fjh_pkg::HOLD_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   fjh_link_if.host bus
);
   import fjh_pkg::*;
   localparam int HW = $clog2(HOLD_CYCLES + 1);

   if (HOLD_CYCLES < 1) begin : g_chk
      $error("hold time must be at least one cycle");
   end

   // address decode shared by read and write
   function automatic logic mapped(input logic [11:0] a);
      return a == REG_CMD || a == REG_STAT;
   endfunction

   // --------------------------------------------------------------
   // apb slave, one wait state
   // --------------------------------------------------------------
   logic [8:0] cmd; // wanted image plus link enable
   logic acc; // access phase in its first cycle
   logic done; // completing edge
   logic pend; // wanted image not yet on the link
   assign acc = psel & penable & !pready;
   assign done = psel & penable & pready;

   // ready, error and read data for each access
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= acc;
         pslverr <= acc & !mapped(paddr);
         if (acc && !pwrite && paddr == REG_CMD) begin
            prdata <= {23'h00_0000, cmd};
         end else if (acc && !pwrite && paddr == REG_STAT) begin
            prdata <= {23'h00_0000, pend, 3'h0, bus.jog_out[B_PERMIT],
               bus.jog_out[B_AX +: AXES]};
         end else begin
            prdata <= '0;
         end
      end
   end

   // command register write
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd <= CMD_RST;
      end else if (done && pwrite && paddr == REG_CMD) begin
         cmd <= pwdata[8:0];
      end
   end

   // --------------------------------------------------------------
   // link driver
   // --------------------------------------------------------------
   logic [HW-1:0] hold; // cycles until the image may change
   logic [IMG_W-1:0] want; // image allowed to be sent
   // a new axis request waits for permit; dropping is always allowed
   always_comb begin
      want = cmd[IMG_W-1:0];
      want[B_AX +: AXES] = cmd[B_AX +: AXES] &
         (bus.jog_in[B_AX +: AXES] | {AXES{bus.jog_out[B_PERMIT]}});
   end
   assign pend = want != cmd[IMG_W-1:0] || bus.jog_in != want;

   // any image change restarts the hold time
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold <= '0;
         bus.jog_in <= '0;
         bus.link_ok <= 1'b0;
      end else begin
         bus.link_ok <= cmd[CMD_LINK];
         if (hold != '0) begin
            hold <= hold - 1'b1;
         end else if (bus.jog_in != want) begin
            bus.jog_in <= want;
            hold <= HW'(HOLD_CYCLES);
         end
      end
   end
endmodule
`default_nettype wire

// file: fjh_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// link image watcher between host and device
// ---------------------------------------------
module fjh_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [fjh_pkg::IMG_W-1:0] jog_in,
   input wire logic [fjh_pkg::IMG_W-1:0] jog_out,
   input wire logic link_ok
);
   import fjh_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // unused status bits stay low
   property p_unused;
      jog_out[7:5] == 3'h0;
   endproperty
   a_unused: assert property (p_unused) else $error("unused image bits set");
   // never two moving bits
   property p_one_axis;
      $onehot0(jog_out[3:0]);
   endproperty
   a_one_axis: assert property (p_one_axis) else $error("two axes moving");
   // permit and moving exclusive
   property p_busy_no_permit;
      jog_out[4] |-> jog_out[3:0] == 4'h0;
   endproperty
   a_busy_no_permit: assert property (p_busy_no_permit) else $error("permit while moving");
   // accept only from permit, permit drops on same edge
   property p_accept;
      $rose(|jog_out[3:0]) |-> !jog_out[4] && $past(jog_out[4]);
   endproperty
   a_accept: assert property (p_accept) else $error("accept without permit");
   // link loss clears the image
   property p_link_loss;
      !link_ok |=> jog_out == 8'h00;
   endproperty
   a_link_loss: assert property (p_link_loss) else $error("image kept on link loss");
   // filter hides a fresh request for a while
   property p_filter_min;
      $rose(jog_in[0]) |-> (!jog_out[0]) [*8];
   endproperty
   a_filter_min: assert property (p_filter_min) else $error("request seen too early");
   // permitted request with a mode is taken in time
   property p_filter_max;
      $rose(jog_in[0]) && jog_out[4] && (|jog_in[6:4]) && link_ok |-> ##[8:18] jog_out[0];
   endproperty
   a_filter_max: assert property (p_filter_max) else $error("request not taken");
   // release stops the axis after the filter
   property p_release;
      $fell(jog_in[0]) && jog_out[0] && link_ok |-> jog_out[0] [*8] ##[1:10] !jog_out[0];
   endproperty
   a_release: assert property (p_release) else $error("release timing wrong");
   // permit returns with moving low
   property p_permit_back;
      $fell(jog_out[0]) && link_ok && $past(link_ok) |-> jog_out[4];
   endproperty
   a_permit_back: assert property (p_permit_back) else $error("permit not restored");
endmodule
`default_nettype wire

// file: test_fieldbus_axis_jog_handshake.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// both ends joined, apb drives the host
// ---------------------------------------------
module test_fieldbus_axis_jog_handshake;
   import fjh_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rdv;
   logic pready, pslverr, errv;
   logic [7:0] io_jog_in = 8'h00;
   logic [7:0] io_jog_out;
   logic [4:0] inh = 5'h00; // pendant, tool, program, homing, error
   logic running_out, move_en, move_neg, move_inch;
   logic [3:0] present = 4'hf;
   logic [3:0] known = 4'h0;
   logic [3:0] lpos = 4'h0;
   logic [3:0] lneg = 4'h0;
   logic [15:0] low_speed = 16'h0123;
   logic [15:0] high_speed = 16'h0456;
   logic [15:0] inch_dist = 16'h0078;
   logic [15:0] move_speed, move_dist;
   logic [1:0] move_axis;
   int num_errors = 0;
   int check_count = 0;
   wire logic [8:0] st; // motion enable over status image
   always #12.5 core_clk = ~core_clk;
   fjh_link_if link();
   fjh_device #(.TICK_CYCLES(4), .FILT_TICKS_P(3), .SPD_W(16)) fjh_device_i (.core_clk, .rst_n, .bus(link),
      .io_jog_in, .io_jog_out, .pendant_on(inh[0]), .tool_busy(inh[1]), .prog_running(inh[2]),
      .homing_active(inh[3]), .error_active(inh[4]), .running_out, .axis_present(present), .pos_known(known),
      .lim_pos_hit(lpos), .lim_neg_hit(lneg), .low_speed, .high_speed, .inch_dist, .move_en, .move_axis,
      .move_neg, .move_speed, .move_inch, .move_dist);
   fjh_host #(.HOLD_CYCLES(64)) fjh_host_i (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .bus(link));
   fjh_checker fjh_checker_i (.core_clk, .rst_n, .jog_in(link.jog_in), .jog_out(link.jog_out),
      .link_ok(link.link_ok));
   assign st = {move_en, link.jog_out};
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", w, e, s);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         num_errors++;
         print_verdict();
      end
   endtask
   task automatic cmd(input logic [8:0] c);
      apb(1'b1, REG_CMD, 32'(c));
   endtask
   // bounded wait for a state
   task automatic wait_st(input logic [8:0] e, input int lim);
      int n;
      n = 0;
      while (st !== e && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      chk("state", 32'(st), 32'(e));
      if (st !== e) print_verdict();
   endtask
   // state must not move
   task automatic hold(input logic [8:0] e, input int n);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         @(posedge core_clk);
         if (st !== e) bad = 1'b1;
      end
      chk("steady", 32'(bad), 32'h0000_0000);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_regs;
      apb(1'b0, REG_CMD, 32'h0000_0000);
      chk("cmd reset", rdv, 32'h0000_0000);
      cmd(9'h100);
      wait_st(9'h010, 20);
      apb(1'b0, REG_STAT, 32'h0000_0000);
      chk("stat", rdv, 32'h0000_0010);
      apb(1'b1, REG_STAT, 32'hffff_ffff);
      apb(1'b0, REG_CMD, 32'h0000_0000);
      chk("cmd kept", rdv, 32'h0000_0100);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk("slverr", 32'(errv), 32'h0000_0001);
      chk("rd zero", rdv, 32'h0000_0000);
      $display("test regs done");
   endtask
   task automatic t_modes;
      logic [7:0] tm [5];
      logic [7:0] c;
      int ax;
      tm = '{8'h21, 8'hC2, 8'h14, 8'hF8, 8'h61};
      for (int k = 0; k < 5; k++) begin
         c = tm[k];
         ax = 0;
         for (int b = 0; b < 4; b++) if (c[b]) ax = b;
         cmd({1'b1, c});
         wait_st({5'h10, c[3:0]}, 200);
         chk("axis", 32'(move_axis), 32'(ax));
         chk("neg", 32'(move_neg), 32'(c[7]));
         chk("inch", 32'(move_inch), 32'(c[4]));
         chk("speed", 32'(move_speed), 32'((c[4] | c[5]) ? low_speed : high_speed));
         if (c[4]) chk("dist", 32'(move_dist), 32'(inch_dist));
         chk("io copy", 32'(io_jog_out), 32'(c[3:0]));
         if (k == 0) begin
            cmd(9'h1C1);
            hold(9'h101, 90);
            chk("dir kept", 32'(move_neg), 32'h0000_0000);
            chk("spd kept", 32'(move_speed), 32'(low_speed));
         end
         cmd(9'h100);
         wait_st(9'h010, 200);
      end
      $display("test modes done");
   endtask
   task automatic t_permit;
      for (int i = 0; i < 5; i++) begin
         inh <= 5'(1 << i);
         repeat (3) @(posedge core_clk);
         chk("permit off", 32'(link.jog_out[4]), 32'h0000_0000);
         chk("running", 32'(running_out), 32'(i == 2 || i == 3));
         inh <= 5'h00;
         repeat (3) @(posedge core_clk);
         chk("permit on", 32'(link.jog_out[4]), 32'h0000_0001);
      end
      inh <= 5'h01;
      io_jog_in <= 8'h22;
      repeat (2) @(posedge core_clk);
      hold(9'h000, 30);
      inh <= 5'h00;
      repeat (3) @(posedge core_clk);
      hold(9'h010, 30);
      io_jog_in <= 8'h00;
      repeat (20) @(posedge core_clk);
      io_jog_in <= 8'h22;
      wait_st(9'h102, 40);
      chk("io out", 32'(io_jog_out), 32'h0000_0002);
      io_jog_in <= 8'h00;
      wait_st(9'h010, 40);
      $display("test permit done");
   endtask
   task automatic t_misc;
      cmd(9'h121);
      wait_st(9'h101, 200);
      io_jog_in <= 8'h22;
      hold(9'h101, 40);
      io_jog_in <= 8'h00;
      repeat (20) @(posedge core_clk);
      cmd(9'h100);
      wait_st(9'h010, 200);
      present <= 4'h7;
      cmd(9'h128);
      apb(1'b0, REG_STAT, 32'h0000_0000);
      chk("pend", rdv, 32'h0000_0110);
      hold(9'h010, 150);
      cmd(9'h100);
      repeat (100) @(posedge core_clk);
      present <= 4'hf;
      cmd(9'h101);
      hold(9'h010, 150);
      cmd(9'h100);
      repeat (100) @(posedge core_clk);
      known <= 4'h1;
      lpos <= 4'h1;
      cmd(9'h121);
      wait_st(9'h001, 200);
      hold(9'h001, 20);
      known <= 4'h0;
      wait_st(9'h101, 5);
      cmd(9'h100);
      wait_st(9'h010, 200);
      lpos <= 4'h0;
      $display("test axis limits done");
   endtask
   task automatic t_link;
      cmd(9'h121);
      wait_st(9'h101, 200);
      cmd(9'h021);
      wait_st(9'h000, 5);
      chk("link", 32'(link.link_ok), 32'h0000_0000);
      cmd(9'h000);
      repeat (150) @(posedge core_clk);
      cmd(9'h100);
      wait_st(9'h010, 200);
      $display("test link done");
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      t_regs();
      t_modes();
      t_permit();
      t_misc();
      t_link();
      print_verdict();
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge core_clk);
      num_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
